// ### verilog/pqu_pkg.sv
// Shared types and constants of the product/quotient unit
package pqu_pkg;

   // ----------------------------------------------------------------
   // Operations presented by the integer pipe
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      op_product_to_result_pair,
      op_accumulate_add_product,
      op_accumulate_subtract_product,
      op_product_to_register,
      op_quotient_remainder_op,
      op_read_upper_word,
      op_read_bottom_word
   } pqu_op_e;

   typedef enum logic [1:0] {
      st_idle,
      st_mul2,
      st_div
   } unit_state_e;

   typedef struct packed {
      pqu_op_e     op;
      logic        is_signed;
      logic [31:0] left_operand;
      logic [31:0] right_operand;
      logic [4:0]  dest;
   } pqu_req_s;

   typedef struct packed {
      logic        valid;
      logic [4:0]  dest;
      logic [31:0] data;
   } rf_write_s;

   // ----------------------------------------------------------------
   // Divide early-in: iterations skipped and repeat rate per width
   // ----------------------------------------------------------------
   localparam logic [4:0] DIV_SKIP_FIT8  = 5'h17;
   localparam logic [4:0] DIV_SKIP_FIT16 = 5'h0f;
   localparam logic [4:0] DIV_SKIP_FIT24 = 5'h07;
   localparam logic [4:0] DIV_SKIP_FULL  = 5'h00;
   localparam logic [5:0] DIV_RPT_FIT8   = 6'h0b;
   localparam logic [5:0] DIV_RPT_FIT16  = 6'h12;
   localparam logic [5:0] DIV_RPT_FIT24  = 6'h19;
   localparam logic [5:0] DIV_RPT_FULL   = 6'h20;
   localparam logic [5:0] DIV_BITS       = 6'h20;

   localparam rf_write_s  RF_WRITE_IDLE  = '0;
   localparam logic [31:0] WORD_RESET    = 32'h0;

endpackage

// ### verilog/booth_slice_mul.sv
// Radix-4 booth multiplier of a signed left operand by a signed slice
`timescale 1ns/1ps
`default_nettype none
module booth_slice_mul #(
   parameter int WA = 33,
   parameter int WB = 17
) (
   input  wire logic signed [WA-1:0]    mcand,
   input  wire logic signed [WB-1:0]    mplier,
   output logic signed [WA+WB-1:0]      prod
);
   localparam int WP = WA + WB;
   localparam int ND = (WB + 1) / 2;

   if (WB < 3 || (WB % 2) == 0 || WA < 2) begin : g_bad_width
      $error("booth_slice_mul: WB must be odd and at least 3");
   end

   logic [2*ND:0]          digits;
   logic signed [WP-1:0]   m1;
   logic signed [WP-1:0]   m2;
   logic signed [WP-1:0]   pp [ND];

   // One spare sign bit pads the last digit triple
   assign digits = {{(2*ND-WB){mplier[WB-1]}}, mplier, 1'b0};
   assign m1     = {{WB{mcand[WA-1]}}, mcand};
   assign m2     = m1 <<< 1;

   // ----------------------------------------------------------------
   // One partial product per recoded digit
   // ----------------------------------------------------------------
   for (genvar i = 0; i < ND; i++) begin : g_digit
      always_comb begin
         case (digits[2*i+2 -: 3])
            3'h1, 3'h2: pp[i] = m1 <<< (2*i);
            3'h3:       pp[i] = m2 <<< (2*i);
            3'h4:       pp[i] = (-m2) <<< (2*i);
            3'h5, 3'h6: pp[i] = (-m1) <<< (2*i);
            default:    pp[i] = '0;
         endcase
      end
   end

   // Modular sum is exact: the true product fits WP bits
   always_comb begin
      prod = '0;
      for (int k = 0; k < ND; k++) begin
         prod = prod + pp[k];
      end
   end
endmodule
`default_nettype wire

// ### verilog/product_quotient_unit.sv
// Multiply/divide unit running beside the integer pipe
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Own pipeline; keeps advancing whatever the integer pipe does.
// - Booth 32x16 multiplier, result pair, divide machine, muxing and control.
// - Pass count set by right operand: fits 16 bits one pass, else two.
// - A 16-bit multiply every clock; 32x32 multiplies every other clock.
// - Operand size found from operand values, never from the instruction.
// - Divide resolves one quotient bit per clock; 8/16-bit dividends add 2/1 padding clocks.
// - Dividend fitting 8/16/24 bits skips 23/15/7 iterations.
// - Any unit request while a divide runs stalls the integer pipe.
// - Pair multiplies 1/1 or 2/2; register multiply 2/1 or 3/2.
// - Divides take 11/11, 18/18, 25/25, 32/32 clocks by dividend width.
// - Results land in upper and bottom words; moves read them out.
// - Register multiply writes its low word straight to a general register.
// - Accumulate-add adds the product to the pair, keeping the sum.
// - Accumulate-subtract subtracts the product from the pair.
module product_quotient_unit (
   input  wire logic                core_clk,
   input  wire logic                nrst,
   input  wire logic                req_valid,
   input  wire pqu_pkg::pqu_req_s   req,
   output logic                     req_ready,
   output pqu_pkg::rf_write_s       mul_rf_wr,
   output pqu_pkg::rf_write_s       move_rf_wr,
   output logic                     div_busy
);
   import pqu_pkg::*;

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   unit_state_e   state_r,       state_nxt;
   pqu_op_e       op_r,          op_nxt;
   logic          signed_r,      signed_nxt;
   logic [31:0]   left_r,        left_nxt;
   logic [31:0]   right_r,       right_nxt;
   logic [4:0]    dest_r,        dest_nxt;
   logic [49:0]   partial_r,     partial_nxt;
   logic [31:0]   upper_r,       upper_nxt;
   logic [31:0]   bottom_r,      bottom_nxt;
   logic [31:0]   rem_r,         rem_nxt;
   logic [31:0]   quo_r,         quo_nxt;
   logic [31:0]   dvs_r,         dvs_nxt;
   logic          neg_q_r,       neg_q_nxt;
   logic          neg_rem_r,     neg_rem_nxt;
   logic [5:0]    iter_r,        iter_nxt;
   logic [5:0]    cnt_r,         cnt_nxt;
   rf_write_s     rf_pend_r,     rf_pend_nxt;
   rf_write_s     rf_out_r,      rf_out_nxt;
   rf_write_s     move_r,        move_nxt;

   // ----------------------------------------------------------------
   // Issue and operand sizing
   // ----------------------------------------------------------------
   logic          accept;
   logic          is_mul_op;
   logic          right_fits16;
   logic          fit8;
   logic          fit16;
   logic          fit24;
   logic signed [32:0] mcand;
   logic signed [16:0] slice;
   logic signed [49:0] pass_prod;
   logic [63:0]   full_prod;
   logic [63:0]   pair_now;
   logic [63:0]   pair_new;
   logic          mul_done;
   pqu_op_e       done_op;
   logic [4:0]    done_dest;

   // Integer pipe stall never reaches this unit; only our own state gates issue
   assign req_ready = (state_r == st_idle);
   assign accept    = req_valid && req_ready;
   assign div_busy  = (state_r == st_div);
   assign is_mul_op = (req.op == op_product_to_result_pair) ||
                      (req.op == op_accumulate_add_product) ||
                      (req.op == op_accumulate_subtract_product) ||
                      (req.op == op_product_to_register);

   // Width taken from the values themselves
   assign right_fits16 = req.is_signed ?
      (req.right_operand[31:15] == {17{req.right_operand[15]}}) :
      (req.right_operand[31:16] == 16'h0);
   assign fit8  = req.is_signed ?
      (req.left_operand[31:7] == {25{req.left_operand[7]}}) :
      (req.left_operand[31:8] == 24'h0);
   assign fit16 = req.is_signed ?
      (req.left_operand[31:15] == {17{req.left_operand[15]}}) :
      (req.left_operand[31:16] == 16'h0);
   assign fit24 = req.is_signed ?
      (req.left_operand[31:23] == {9{req.left_operand[23]}}) :
      (req.left_operand[31:24] == 8'h0);

   // ----------------------------------------------------------------
   // Multiplier pass select
   // ----------------------------------------------------------------
   // An extra top bit lets the signed slice also carry unsigned values
   always_comb begin
      if (state_r == st_mul2) begin
         mcand = {signed_r & left_r[31], left_r};
         slice = {signed_r & right_r[31], right_r[31:16]};
      end else if (right_fits16) begin
         mcand = {req.is_signed & req.left_operand[31], req.left_operand};
         slice = {req.is_signed & req.right_operand[15], req.right_operand[15:0]};
      end else begin
         mcand = {req.is_signed & req.left_operand[31], req.left_operand};
         slice = {1'b0, req.right_operand[15:0]};
      end
   end

   booth_slice_mul #(
      .WA (33),
      .WB (17)
   ) u_booth (
      .mcand  (mcand),
      .mplier (slice),
      .prod   (pass_prod)
   );

   always_comb begin
      if (state_r == st_mul2) begin
         full_prod = {pass_prod[47:0], 16'h0} + {{14{partial_r[49]}}, partial_r};
      end else begin
         full_prod = {{14{pass_prod[49]}}, pass_prod};
      end
   end

   assign mul_done  = (state_r == st_mul2) || (accept && is_mul_op && right_fits16);
   assign done_op   = (state_r == st_mul2) ? op_r : req.op;
   assign done_dest = (state_r == st_mul2) ? dest_r : req.dest;
   assign pair_now  = {upper_r, bottom_r};

   always_comb begin
      case (done_op)
         op_accumulate_add_product:      pair_new = pair_now + full_prod;
         op_accumulate_subtract_product: pair_new = pair_now - full_prod;
         default:                        pair_new = full_prod;
      endcase
   end

   // ----------------------------------------------------------------
   // Divide step, shared by the issue cycle and the running cycles
   // ----------------------------------------------------------------
   logic          div_start;
   logic [31:0]   mag_left;
   logic [31:0]   mag_right;
   logic [4:0]    skip;
   logic [5:0]    rpt;
   logic [31:0]   cur_rem;
   logic [31:0]   cur_quo;
   logic [31:0]   cur_dvs;
   logic [5:0]    cur_iter;
   logic [32:0]   trial;
   logic [31:0]   step_rem;
   logic [31:0]   step_quo;
   logic [5:0]    step_iter;
   logic          cur_neg_q;
   logic          cur_neg_rem;
   logic          div_final;

   assign div_start = accept && (req.op == op_quotient_remainder_op);
   assign mag_left  = (req.is_signed && req.left_operand[31]) ?
                      -req.left_operand : req.left_operand;
   assign mag_right = (req.is_signed && req.right_operand[31]) ?
                      -req.right_operand : req.right_operand;

   always_comb begin
      if (fit8) begin
         skip = DIV_SKIP_FIT8;
         rpt  = DIV_RPT_FIT8;
      end else if (fit16) begin
         skip = DIV_SKIP_FIT16;
         rpt  = DIV_RPT_FIT16;
      end else if (fit24) begin
         skip = DIV_SKIP_FIT24;
         rpt  = DIV_RPT_FIT24;
      end else begin
         skip = DIV_SKIP_FULL;
         rpt  = DIV_RPT_FULL;
      end
   end

   always_comb begin
      if (div_start) begin
         cur_rem     = WORD_RESET;
         cur_quo     = mag_left << skip;
         cur_dvs     = mag_right;
         cur_iter    = DIV_BITS - {1'b0, skip};
         cur_neg_q   = req.is_signed && (req.left_operand[31] ^ req.right_operand[31]);
         cur_neg_rem = req.is_signed && req.left_operand[31];
      end else begin
         cur_rem     = rem_r;
         cur_quo     = quo_r;
         cur_dvs     = dvs_r;
         cur_iter    = iter_r;
         cur_neg_q   = neg_q_r;
         cur_neg_rem = neg_rem_r;
      end
      trial     = {cur_rem, cur_quo[31]};
      step_rem  = cur_rem;
      step_quo  = cur_quo;
      step_iter = cur_iter;
      // Restoring step on magnitudes, one quotient bit per clock
      if (cur_iter != 6'h0) begin
         step_iter = cur_iter - 6'h1;
         if (trial >= {1'b0, cur_dvs}) begin
            step_rem = 32'(trial - {1'b0, cur_dvs});
            step_quo = {cur_quo[30:0], 1'b1};
         end else begin
            step_rem = trial[31:0];
            step_quo = {cur_quo[30:0], 1'b0};
         end
      end
   end

   // Padding cycles after the last iteration hold the values
   assign div_final = (state_r == st_div) && (cnt_r == 6'h1);

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      state_nxt   = state_r;
      op_nxt      = op_r;
      signed_nxt  = signed_r;
      left_nxt    = left_r;
      right_nxt   = right_r;
      dest_nxt    = dest_r;
      partial_nxt = partial_r;
      upper_nxt   = upper_r;
      bottom_nxt  = bottom_r;
      rem_nxt     = step_rem;
      quo_nxt     = step_quo;
      dvs_nxt     = cur_dvs;
      neg_q_nxt   = cur_neg_q;
      neg_rem_nxt = cur_neg_rem;
      iter_nxt    = step_iter;
      cnt_nxt     = cnt_r;
      rf_pend_nxt = RF_WRITE_IDLE;
      rf_out_nxt  = rf_pend_r;
      move_nxt    = RF_WRITE_IDLE;

      if (accept) begin
         op_nxt     = req.op;
         signed_nxt = req.is_signed;
         left_nxt   = req.left_operand;
         right_nxt  = req.right_operand;
         dest_nxt   = req.dest;
      end

      if (accept && is_mul_op && !right_fits16) begin
         partial_nxt = pass_prod;
         state_nxt   = st_mul2;
      end

      if (mul_done) begin
         if (done_op == op_product_to_register) begin
            rf_pend_nxt = '{valid: 1'b1, dest: done_dest, data: full_prod[31:0]};
         end else begin
            upper_nxt  = pair_new[63:32];
            bottom_nxt = pair_new[31:0];
         end
         state_nxt = st_idle;
      end

      if (accept && req.op == op_read_upper_word) begin
         move_nxt = '{valid: 1'b1, dest: req.dest, data: upper_r};
      end
      if (accept && req.op == op_read_bottom_word) begin
         move_nxt = '{valid: 1'b1, dest: req.dest, data: bottom_r};
      end

      if (div_start) begin
         cnt_nxt   = rpt - 6'h1;
         state_nxt = st_div;
      end
      if (state_r == st_div) begin
         cnt_nxt = cnt_r - 6'h1;
      end
      if (div_final) begin
         upper_nxt  = neg_rem_r ? -step_rem : step_rem;
         bottom_nxt = neg_q_r ? -step_quo : step_quo;
         state_nxt  = st_idle;
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         state_r   <= st_idle;
         op_r      <= op_product_to_result_pair;
         signed_r  <= 1'b0;
         left_r    <= WORD_RESET;
         right_r   <= WORD_RESET;
         dest_r    <= 5'h0;
         partial_r <= 50'h0;
         upper_r   <= WORD_RESET;
         bottom_r  <= WORD_RESET;
         rem_r     <= WORD_RESET;
         quo_r     <= WORD_RESET;
         dvs_r     <= WORD_RESET;
         neg_q_r   <= 1'b0;
         neg_rem_r <= 1'b0;
         iter_r    <= 6'h0;
         cnt_r     <= 6'h0;
         rf_pend_r <= RF_WRITE_IDLE;
         rf_out_r  <= RF_WRITE_IDLE;
         move_r    <= RF_WRITE_IDLE;
      end else begin
         state_r   <= state_nxt;
         op_r      <= op_nxt;
         signed_r  <= signed_nxt;
         left_r    <= left_nxt;
         right_r   <= right_nxt;
         dest_r    <= dest_nxt;
         partial_r <= partial_nxt;
         upper_r   <= upper_nxt;
         bottom_r  <= bottom_nxt;
         rem_r     <= rem_nxt;
         quo_r     <= quo_nxt;
         dvs_r     <= dvs_nxt;
         neg_q_r   <= neg_q_nxt;
         neg_rem_r <= neg_rem_nxt;
         iter_r    <= iter_nxt;
         cnt_r     <= cnt_nxt;
         rf_pend_r <= rf_pend_nxt;
         rf_out_r  <= rf_out_nxt;
         move_r    <= move_nxt;
      end
   end

   assign mul_rf_wr  = rf_out_r;
   assign move_rf_wr = move_r;
endmodule
`default_nettype wire

// ### tb/pqu_checker.sv
// Port assertions for the product/quotient unit
`timescale 1ns/1ps
`default_nettype none
module pqu_checker (
   input wire logic               core_clk,
   input wire logic               nrst,
   input wire logic               req_valid,
   input wire pqu_pkg::pqu_req_s  req,
   input wire logic               req_ready,
   input wire pqu_pkg::rf_write_s mul_rf_wr,
   input wire pqu_pkg::rf_write_s move_rf_wr,
   input wire logic               div_busy
);
   import pqu_pkg::*;
   // ----------
   // Take decode
   // ----------
   logic take, fits16, wide, div_take, rd_take, rm16, rm32;
   // Gated by reset so nothing counts as taken while the unit is held
   assign take = nrst && req_valid && req_ready;
   assign fits16 = req.is_signed ? (&req.right_operand[31:15] || ~|req.right_operand[31:15])
      : ~|req.right_operand[31:16];
   assign wide = take && !fits16 && !(req.op inside {op_quotient_remainder_op,
      op_read_upper_word, op_read_bottom_word});
   assign div_take = take && req.op == op_quotient_remainder_op;
   assign rd_take = take && req.op inside {op_read_upper_word, op_read_bottom_word};
   assign rm16 = take && fits16 && req.op == op_product_to_register;
   assign rm32 = wide && req.op == op_product_to_register;
   // ----------
   // Divide length
   // ----------
   // Busy run is counted here; a long repetition would not unroll
   logic       left8, left16, left24;
   logic [5:0] busy_len;
   logic [5:0] exp_len;
   assign left8 = req.is_signed ? (&req.left_operand[31:7] || ~|req.left_operand[31:7])
      : ~|req.left_operand[31:8];
   assign left16 = req.is_signed ? (&req.left_operand[31:15] || ~|req.left_operand[31:15])
      : ~|req.left_operand[31:16];
   assign left24 = req.is_signed ? (&req.left_operand[31:23] || ~|req.left_operand[31:23])
      : ~|req.left_operand[31:24];
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         busy_len <= 6'h0;
         exp_len  <= 6'h0;
      end else begin
         busy_len <= div_busy ? busy_len + 6'h1 : 6'h0;
         if (div_take) begin
            exp_len <= left8 ? 6'h0a : left16 ? 6'h11 : left24 ? 6'h18 : 6'h1f;
         end
      end
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (!nrst);
   // ----------
   // Properties
   // ----------
   a_busy_stalls: assert property (div_busy |-> !req_ready)
      else $error("request open while divide runs");
   a_div_starts: assert property (div_take |=> div_busy)
      else $error("divide did not start");
   a_div_cause: assert property ($rose(div_busy) |-> $past(div_take))
      else $error("divide busy without a divide");
   a_div_span: assert property ($fell(div_busy) |-> busy_len == exp_len)
      else $error("divide length does not match dividend width");
   a_div_bound: assert property (div_busy |-> busy_len < exp_len)
      else $error("divide busy beyond its length");
   a_wide_stall: assert property (wide |=> !req_ready ##1 req_ready)
      else $error("wide multiply stall not one cycle");
   a_read_answer: assert property (rd_take |=>
      (move_rf_wr.valid && move_rf_wr.dest == $past(req.dest)))
      else $error("read answer missing");
   a_read_cause: assert property (move_rf_wr.valid |-> $past(rd_take))
      else $error("read answer without a read");
   a_regmul_lat: assert property (rm16 |-> ##2
      (mul_rf_wr.valid && mul_rf_wr.dest == $past(req.dest, 2)))
      else $error("register multiply late");
   a_regmul_src: assert property (mul_rf_wr.valid |-> $past(rm16, 2) || $past(rm32, 3))
      else $error("register write without its multiply");
endmodule
bind product_quotient_unit pqu_checker pqu_checker_i (.core_clk(core_clk), .nrst(nrst),
   .req_valid(req_valid), .req(req), .req_ready(req_ready), .mul_rf_wr(mul_rf_wr),
   .move_rf_wr(move_rf_wr), .div_busy(div_busy));
`default_nettype wire

// ### tb/integer_pipe_model.sv
// Integer pipe stand-in: presents unit requests and stalls while refused
`timescale 1ns/1ps
`default_nettype none
module integer_pipe_model (
   input  wire logic              core_clk,
   input  wire logic              req_ready,
   output var  logic              req_valid,
   output var  pqu_pkg::pqu_req_s req
);
   import pqu_pkg::*;
   int cyc = 0;

   always @(posedge core_clk) cyc <= cyc + 1;

   initial begin
      req_valid = 1'b0;
      req = '0;
   end

   // Ready is combinational; read mid-cycle where inputs have settled
   task automatic issue(input pqu_req_s r, output int t);
      logic ok;
      req_valid = 1'b1;
      req = r;
      do begin
         @(negedge core_clk);
         ok = req_ready;
         @(posedge core_clk);
      end while (!ok);
      #1;
      t = cyc;
   endtask

   // Released lines show a changed pattern, never the stale request
   task automatic idle();
      req_valid = 1'b0;
      req = pqu_req_s'(~req);
   endtask
endmodule
`default_nettype wire

// ### tb/tb_product_quotient_unit.sv
// Self-checking bench for the product/quotient unit
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin \
   total_checks++; \
   if ((got) !== (exp)) begin \
      bad_count++; \
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp); \
   end \
end
module tb_product_quotient_unit;
   import pqu_pkg::*;
   logic        core_clk = 1'b0;
   logic        nrst = 1'b0;
   logic        req_valid;
   logic        req_ready;
   logic        div_busy;
   pqu_req_s    req;
   rf_write_s   mul_rf_wr;
   rf_write_s   move_rf_wr;
   int          bad_count = 0;
   int          total_checks = 0;
   int          prev_t = 0;
   int          prev_rpt = 0;
   int          t;
   int          c;
   logic [63:0] pair = '0;
   logic [36:0] mul_exp [int];
   logic [36:0] mv_exp [int];
   pqu_req_s    corner [7] = '{
      '{op_read_upper_word, 1'b0, 32'h0, 32'h0, 5'h01},
      '{op_product_to_result_pair, 1'b1, 32'h80000000, 32'hffff8000, 5'h02},
      '{op_accumulate_add_product, 1'b1, 32'h7fffffff, 32'h00008000, 5'h03},
      '{op_accumulate_subtract_product, 1'b0, 32'hffffffff, 32'h00008000, 5'h04},
      '{op_product_to_register, 1'b0, 32'hffffffff, 32'h00010000, 5'h1f},
      '{op_quotient_remainder_op, 1'b1, 32'hffffff80, 32'h00000007, 5'h05},
      '{op_quotient_remainder_op, 1'b0, 32'h00000080, 32'h00000003, 5'h06}};

   always #50 core_clk = ~core_clk;

   product_quotient_unit product_quotient_unit_i (.core_clk(core_clk), .nrst(nrst),
      .req_valid(req_valid), .req(req), .req_ready(req_ready), .mul_rf_wr(mul_rf_wr),
      .move_rf_wr(move_rf_wr), .div_busy(div_busy));
   integer_pipe_model integer_pipe_model_i (.core_clk(core_clk), .req_ready(req_ready),
      .req_valid(req_valid), .req(req));

   // ----------
   // Expectations
   // ----------
   function automatic logic fits(logic [31:0] v, int n, logic sg);
      logic signed [31:0] s;
      s = $signed(v) >>> (n - 1);
      if (sg) return s == 0 || s == -1;
      return (v >> n) == 32'h0;
   endfunction

   function automatic logic [63:0] prod(logic [31:0] a, logic [31:0] b, logic sg);
      logic signed [63:0] x;
      logic signed [63:0] y;
      x = sg ? $signed(a) : $signed({32'h0, a});
      y = sg ? $signed(b) : $signed({32'h0, b});
      return x * y;
   endfunction

   function automatic logic [63:0] quo(logic [31:0] a, logic [31:0] b, logic sg);
      logic signed [31:0] sa;
      logic signed [31:0] sb;
      sa = a;
      sb = b;
      if (sg) return {sa % sb, sa / sb};
      return {a % b, a / b};
   endfunction

   function automatic int rpt(pqu_req_s r);
      if (r.op == op_quotient_remainder_op) begin
         if (fits(r.left_operand, 8, r.is_signed)) return 11;
         if (fits(r.left_operand, 16, r.is_signed)) return 18;
         if (fits(r.left_operand, 24, r.is_signed)) return 25;
         return 32;
      end
      if (r.op inside {op_read_upper_word, op_read_bottom_word}) return 1;
      return fits(r.right_operand, 16, r.is_signed) ? 1 : 2;
   endfunction

   // Width class drawn as a 0/8/16/24-bit shift so every early-out length gets hit
   function automatic logic [31:0] rnd(logic sg);
      logic [31:0] x;
      int          sh;
      x = $urandom;
      sh = 8 * $urandom_range(3);
      if (sg) return $signed(x) >>> sh;
      return x >> sh;
   endfunction

   // ----------
   // Driving and watching
   // ----------
   task automatic run(input pqu_req_s r);
      logic [63:0] p;
      p = prod(r.left_operand, r.right_operand, r.is_signed);
      integer_pipe_model_i.issue(r, t);
      if (prev_rpt > 0) `CHK(t - prev_t, prev_rpt)
      case (r.op)
         op_product_to_result_pair:      pair = p;
         op_accumulate_add_product:      pair = pair + p;
         op_accumulate_subtract_product: pair = pair - p;
         op_product_to_register:         mul_exp[t + rpt(r)] = {r.dest, p[31:0]};
         op_quotient_remainder_op:       pair = quo(r.left_operand, r.right_operand, r.is_signed);
         op_read_upper_word:             mv_exp[t] = {r.dest, pair[63:32]};
         default:                        mv_exp[t] = {r.dest, pair[31:0]};
      endcase
      prev_t = t;
      prev_rpt = rpt(r);
   endtask

   always @(negedge core_clk) begin
      c = integer_pipe_model_i.cyc;
      if (nrst) begin
         `CHK(mul_rf_wr.valid, 1'(mul_exp.exists(c)))
         `CHK(move_rf_wr.valid, 1'(mv_exp.exists(c)))
         if (mul_exp.exists(c)) `CHK({mul_rf_wr.dest, mul_rf_wr.data}, mul_exp[c])
         if (mv_exp.exists(c)) `CHK({move_rf_wr.dest, move_rf_wr.data}, mv_exp[c])
      end
   end

   task automatic print_verdict();
      $display("checks=%0d mismatches=%0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   initial begin
      pqu_req_s r;
      void'($urandom(32'h76c97adc));
      repeat (12) @(posedge core_clk);
      #1 nrst = 1'b1;
      foreach (corner[i]) run(corner[i]);
      for (int i = 0; i < 80; i++) begin
         r.is_signed = 1'($urandom);
         r.op = pqu_op_e'(3'($urandom_range(4)));
         r.left_operand = rnd(r.is_signed);
         r.right_operand = rnd(r.is_signed);
         r.dest = 5'($urandom);
         if (r.op == op_quotient_remainder_op && r.right_operand inside {32'h0, 32'hffffffff})
            r.right_operand = 32'h3;
         run(r);
         if (i < 2 || $urandom_range(1) == 1) begin
            r.op = op_read_upper_word;
            run(r);
            r.op = op_read_bottom_word;
            run(r);
         end
      end
      integer_pipe_model_i.idle();
      repeat (4) @(posedge core_clk);
      print_verdict();
   end

   // Worst case is about 250 ops of 32 cycles; 20000 cycles leaves ample room
   initial begin
      #2000000;
      bad_count++;
      print_verdict();
   end
endmodule
`default_nettype wire
